// >>> mss_defines.vh
// Constants for the multiphase soft-start sequencer
`ifndef MSS_DEFINES_VH
`define MSS_DEFINES_VH

// Switching period in REF_CLK cycles: 256 x 10 ns, about 390.6 kHz
`define MSS_PERIOD_LAST      8'hFF
// Soft-start counter width and sequence points, in switching cycles
`define MSS_SS_WIDTH         12
`define MSS_TRI_CYCLES       12'h020
`define MSS_CLAMP_CYCLES     12'h096
`define MSS_CLAMP_END        12'h0B6
`define MSS_PG_CYCLE         12'h7FF
// Ramp slope: duty and reference grow by one step every 4 cycles
`define MSS_RAMP_SHIFT       2
// Reset values
`define MSS_CHAN_RESET       3'h4
`define MSS_ACTIVE_RESET     4'hF

`endif

// >>> mss_softstart_sequencer.v
// Soft-start sequencer and phase pulse generator of a multiphase buck controller
`include "mss_defines.vh"

// What this block does
// - Up to four phases; phase 4 tied high, or phases 3 and 4 both tied high, are detected and left unused
// - Active phases are offset by one period divided by the active count
// - Reset holds phase outputs high impedance, pulls power good low and clears oscillator, sawtooth, soft-start
// - Reset release starts soft-start; reset reassertion returns phase outputs to high impedance
// - First 32 switching cycles: reference inhibited, outputs high impedance
// - From cycle 33, about 150 cycles with outputs driven low
// - Then pulses start and width ramps from zero to the normal width
// - Internal reference ramps from zero to the target, one step every 4 switching cycles
// - Power good never asserts before switching cycle 2048
// - Larger error level gives longer duty, with no inversion
// - A phase above the average current gets a shorter pulse
// - Overcurrent during start-up restarts the whole soft-start sequence
// - Power good only with core voltage in limits and soft-start expired
module mss_softstart_sequencer (
    // Clock and power-on reset
    input  wire        REF_CLK,
    input  wire        RST,
    // Phase output pins, three signals each
    input  wire [3:0]  PHASE_DRIVE_IN,
    output wire [3:0]  PHASE_DRIVE_OUT,
    output wire [3:0]  PHASE_DRIVE_OE_N,
    // Control loop inputs, same clock domain
    input  wire [7:0]  ERROR_LEVEL,
    input  wire [7:0]  TARGET_LEVEL,
    input  wire [7:0]  CURRENT_PH1,
    input  wire [7:0]  CURRENT_PH2,
    input  wire [7:0]  CURRENT_PH3,
    input  wire [7:0]  CURRENT_PH4,
    // Comparator pins, asynchronous
    input  wire        OVERCURRENT_IN,
    input  wire        CORE_SENSE_IN,
    // Open-drain power good and status
    output wire        POWER_GOOD_OUT,
    output wire        POWER_GOOD_OE_N,
    output wire [7:0]  REFERENCE_LEVEL,
    output wire [2:0]  ACTIVE_COUNT
);

    localparam ST_TRI   = 2'h0;
    localparam ST_CLAMP = 2'h1;
    localparam ST_RAMP  = 2'h2;

    reg  [3:0]                 phase_meta_reg;
    reg  [3:0]                 phase_sync_reg;
    reg                        oc_meta_reg;
    reg                        oc_sync_reg;
    reg                        core_meta_reg;
    reg                        core_sync_reg;
    reg  [7:0]                 saw_reg;
    reg  [`MSS_SS_WIDTH-1:0]   ss_count_reg;
    reg  [`MSS_SS_WIDTH-1:0]   ss_count_next;
    reg  [2:0]                 chan_count_reg;
    reg  [3:0]                 active_reg;
    reg  [3:0]                 drive_out_reg;
    reg  [3:0]                 drive_oe_n_reg;
    reg                        pg_oe_n_reg;
    reg  [7:0]                 ref_level_reg;
    reg  [7:0]                 ref_level_next;
    reg  [1:0]                 state;
    reg  [7:0]                 ramp_level;
    reg  [7:0]                 avg_current;
    reg  [9:0]                 sum_current;
    reg  [7:0]                 cur;
    reg  [7:0]                 demand;
    reg  [7:0]                 duty;
    reg  [7:0]                 saw_shift;
    reg  [3:0]                 pulse;
    reg  [3:0]                 drive_out_next;
    reg  [3:0]                 drive_oe_n_next;
    reg                        restart;
    integer                    i;

    wire                       period_end;
    wire [`MSS_SS_WIDTH-1:0]   ramp_count;
    wire [31:0]                sum_x85;

    assign period_end = (saw_reg == `MSS_PERIOD_LAST);
    assign ramp_count = ss_count_reg - `MSS_CLAMP_END;
    assign sum_x85    = {22'h0, sum_current} * 32'h00000055;

    function [7:0] mss_min8;
        input [7:0] a;
        input [7:0] b;
        begin
            mss_min8 = (a < b) ? a : b;
        end
    endfunction

    // Sawtooth start of each phase, even spread over one period
    function [7:0] mss_offset;
        input [1:0] idx;
        input [2:0] n;
        begin
            case (n)
                3'h2: mss_offset = idx[0] ? 8'h80 : 8'h00;
                3'h3: mss_offset = (idx == 2'h0) ? 8'h00 : ((idx == 2'h1) ? 8'h55 : 8'hAB);
                default: mss_offset = {idx, 6'h00};
            endcase
        end
    endfunction

    function [7:0] mss_current;
        input [1:0] idx;
        input [31:0] all;
        begin
            mss_current = all[idx*8 +: 8];
        end
    endfunction

    // Pins pass two flip-flops before use
    always @(posedge REF_CLK) begin
        if (RST) begin
            phase_meta_reg <= 4'h0;
            phase_sync_reg <= 4'h0;
            oc_meta_reg    <= 1'b0;
            oc_sync_reg    <= 1'b0;
            core_meta_reg  <= 1'b0;
            core_sync_reg  <= 1'b0;
        end else begin
            phase_meta_reg <= PHASE_DRIVE_IN;
            phase_sync_reg <= phase_meta_reg;
            oc_meta_reg    <= OVERCURRENT_IN;
            oc_sync_reg    <= oc_meta_reg;
            core_meta_reg  <= CORE_SENSE_IN;
            core_sync_reg  <= core_meta_reg;
        end
    end

    // Sequence decode from the soft-start counter
    always @* begin
        if (ss_count_reg < `MSS_TRI_CYCLES) begin
            state = ST_TRI;
        end else if (ss_count_reg < `MSS_CLAMP_END) begin
            state = ST_CLAMP;
        end else begin
            state = ST_RAMP;
        end
        if (state != ST_RAMP) begin
            ramp_level = 8'h00;
        end else if ((ramp_count >> `MSS_RAMP_SHIFT) > 12'h0FF) begin
            ramp_level = 8'hFF;
        end else begin
            ramp_level = ramp_count[`MSS_RAMP_SHIFT +: 8];
        end
    end

    // Overcurrent before power good restarts the sequence
    always @* begin
        restart = oc_sync_reg && (ss_count_reg < `MSS_PG_CYCLE);
        if (restart) begin
            ss_count_next = {`MSS_SS_WIDTH{1'b0}};
        end else if (period_end && (ss_count_reg != `MSS_PG_CYCLE)) begin
            ss_count_next = ss_count_reg + 12'h001;
        end else begin
            ss_count_next = ss_count_reg;
        end
        // Reference held at zero until the ramp, then tracks up to target
        ref_level_next = mss_min8(TARGET_LEVEL, ramp_level);
    end

    // Per-phase duty and pulse
    always @* begin
        sum_current = 10'h000;
        for (i = 0; i < 4; i = i + 1) begin
            if (active_reg[i]) begin
                sum_current = sum_current
                            + {2'h0, mss_current(i[1:0], {CURRENT_PH4, CURRENT_PH3, CURRENT_PH2, CURRENT_PH1})};
            end
        end
        // Divide by three approximated as x85/256; worst error one code
        case (chan_count_reg)
            3'h2:    avg_current = sum_current[8:1];
            3'h3:    avg_current = sum_x85[15:8];
            default: avg_current = sum_current[9:2];
        endcase
        pulse           = 4'h0;
        drive_out_next  = 4'h0;
        drive_oe_n_next = 4'hF;
        cur             = 8'h00;
        demand          = 8'h00;
        duty            = 8'h00;
        saw_shift       = 8'h00;
        for (i = 0; i < 4; i = i + 1) begin
            cur = mss_current(i[1:0], {CURRENT_PH4, CURRENT_PH3, CURRENT_PH2, CURRENT_PH1});
            // Above-average current trims this phase only
            if (cur > avg_current && (cur - avg_current) < ERROR_LEVEL) begin
                demand = ERROR_LEVEL - (cur - avg_current);
            end else if (cur > avg_current) begin
                demand = 8'h00;
            end else begin
                demand = ERROR_LEVEL;
            end
            duty      = mss_min8(demand, ramp_level);
            saw_shift = saw_reg - mss_offset(i[1:0], chan_count_reg);
            pulse[i]  = saw_shift < duty;
            if (active_reg[i] && state != ST_TRI && !restart) begin
                drive_oe_n_next[i] = 1'b0;
                drive_out_next[i]  = (state == ST_RAMP) ? pulse[i] : 1'b0;
            end
        end
    end

    always @(posedge REF_CLK) begin
        if (RST) begin
            saw_reg        <= 8'h00;
            ss_count_reg   <= {`MSS_SS_WIDTH{1'b0}};
            chan_count_reg <= `MSS_CHAN_RESET;
            active_reg     <= `MSS_ACTIVE_RESET;
            drive_out_reg  <= 4'h0;
            drive_oe_n_reg <= 4'hF;
            pg_oe_n_reg    <= 1'b0;
            ref_level_reg  <= 8'h00;
        end else begin
            saw_reg        <= restart ? 8'h00 : saw_reg + 8'h01;
            ss_count_reg   <= ss_count_next;
            drive_out_reg  <= drive_out_next;
            drive_oe_n_reg <= drive_oe_n_next;
            ref_level_reg  <= ref_level_next;
            // Sample ties at the last edge of the high-impedance interval
            if (period_end && ss_count_reg == `MSS_TRI_CYCLES - 12'h001) begin
                if (phase_sync_reg[3] && phase_sync_reg[2]) begin
                    chan_count_reg <= 3'h2;
                    active_reg     <= 4'h3;
                end else if (phase_sync_reg[3]) begin
                    chan_count_reg <= 3'h3;
                    active_reg     <= 4'h7;
                end else begin
                    chan_count_reg <= 3'h4;
                    active_reg     <= 4'hF;
                end
            end
            // Pulls low unless both conditions hold
            pg_oe_n_reg <= core_sync_reg && (ss_count_reg == `MSS_PG_CYCLE);
        end
    end

    assign PHASE_DRIVE_OUT  = drive_out_reg;
    assign PHASE_DRIVE_OE_N = drive_oe_n_reg;
    assign POWER_GOOD_OUT   = 1'b0;
    assign POWER_GOOD_OE_N  = pg_oe_n_reg;
    assign REFERENCE_LEVEL  = ref_level_reg;
    assign ACTIVE_COUNT     = chan_count_reg;

endmodule // mss_softstart_sequencer

// >>> mss_checker.sv
// Port checker for the soft-start sequencer
module mss_checker (
    // Clock and reset
    input wire       REF_CLK,
    input wire       RST,
    // Watched ports
    input wire [3:0] PHASE_DRIVE_OUT,
    input wire [3:0] PHASE_DRIVE_OE_N,
    input wire [7:0] ERROR_LEVEL,
    input wire [7:0] TARGET_LEVEL,
    input wire       OVERCURRENT_IN,
    input wire       CORE_SENSE_IN,
    input wire       POWER_GOOD_OUT,
    input wire       POWER_GOOD_OE_N,
    input wire [7:0] REFERENCE_LEVEL,
    input wire [2:0] ACTIVE_COUNT
);
    timeunit 1ns;
    timeprecision 1ps;
    // Edges since release; a restart only lengthens the sequence, so bounds stay safe
    logic [19:0] cyc_reg;
    logic        oc_reg;
    always_ff @(posedge REF_CLK) begin
        cyc_reg <= RST ? 20'h0 : cyc_reg + {19'h0, ~&cyc_reg};
        oc_reg  <= RST ? 1'b0 : oc_reg | OVERCURRENT_IN;
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    sequence s_err_zero; (ERROR_LEVEL == 8'h00) [*4]; endsequence
    sequence s_oc_held; $past(OVERCURRENT_IN, 3) && $past(OVERCURRENT_IN, 4); endsequence
    property p_release; $fell(RST) |-> PHASE_DRIVE_OE_N == 4'hF && REFERENCE_LEVEL == 8'h00
        && ACTIVE_COUNT == 3'h4 && !POWER_GOOD_OE_N; endproperty
    property p_tri; cyc_reg <= 20'h02000 |-> PHASE_DRIVE_OE_N == 4'hF; endproperty
    property p_clamp; !oc_reg && cyc_reg >= 20'h02008 && cyc_reg < 20'h0B600
        |-> !PHASE_DRIVE_OE_N[0] && !PHASE_DRIVE_OUT[0]; endproperty
    property p_ref_inh; REFERENCE_LEVEL != 8'h00 |-> cyc_reg > 20'h0B600; endproperty
    property p_ref_tgt; REFERENCE_LEVEL <= $past(TARGET_LEVEL); endproperty
    property p_unused; ACTIVE_COUNT != 3'h4
        |-> PHASE_DRIVE_OE_N[3] && (ACTIVE_COUNT != 3'h2 || PHASE_DRIVE_OE_N[2]); endproperty
    property p_duty; s_err_zero |=> (PHASE_DRIVE_OUT & ~PHASE_DRIVE_OE_N) == 4'h0; endproperty
    property p_oc; s_oc_held and (cyc_reg < 20'h7FF00) |-> PHASE_DRIVE_OE_N == 4'hF; endproperty
    property p_pg_early; cyc_reg < 20'h7FF00 |-> !POWER_GOOD_OE_N; endproperty
    property p_pg_sense; POWER_GOOD_OUT == 1'b0 && (!POWER_GOOD_OE_N || $past(CORE_SENSE_IN, 3)); endproperty
    a_release: assert property (p_release) else $error("outputs not at reset values");
    a_tri: assert property (p_tri) else $error("phase driven in first periods");
    a_clamp: assert property (p_clamp) else $error("phase not clamped low");
    a_ref_inh: assert property (p_ref_inh) else $error("reference left zero early");
    a_ref_tgt: assert property (p_ref_tgt) else $error("reference above target");
    a_unused: assert property (p_unused) else $error("unused phase driven");
    a_duty: assert property (p_duty) else $error("pulse with zero demand");
    a_oc: assert property (p_oc) else $error("overcurrent did not float phases");
    a_pg_early: assert property (p_pg_early) else $error("power good too early");
    a_pg_sense: assert property (p_pg_sense) else $error("power good without core sense");
endmodule // mss_checker

bind mss_softstart_sequencer mss_checker u_chk (.REF_CLK, .RST, .PHASE_DRIVE_OUT, .PHASE_DRIVE_OE_N,
    .ERROR_LEVEL, .TARGET_LEVEL, .OVERCURRENT_IN, .CORE_SENSE_IN, .POWER_GOOD_OUT, .POWER_GOOD_OE_N,
    .REFERENCE_LEVEL, .ACTIVE_COUNT);

// >>> mss_gate_model.sv
// Gate driver inputs as seen on the phase pins
module mss_gate_model (
    // Board ties and design drive
    input  wire [3:0] tie,
    input  wire [3:0] drive_out,
    input  wire [3:0] drive_oe_n,
    // Resolved pin levels
    output wire [3:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released driver input sits in its mid band, below the high threshold
    assign pin = tie | (drive_out & ~drive_oe_n);
endmodule // mss_gate_model

// >>> multiphase_softstart_sequencer_bench.sv
// Self-checking bench for the soft-start sequencer
module multiphase_softstart_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        REF_CLK = 1'b0;
    logic        RST = 1'b1;
    logic        oc = 1'b0;
    logic [3:0]  tie = 4'h8;
    logic [7:0]  err_lvl, tgt_lvl, cur, cur_hi;
    logic        core = 1'b1;
    wire         pg_out, pg_oe_n;
    wire  [3:0]  pin, drv_out, drv_oe_n;
    wire  [7:0]  ref_lvl;
    wire  [2:0]  act_cnt;
    int          errors = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          total = 0;
    int          base;
    logic [18:0] k;
    logic [18:0] exp_q[$];
    event        ev;
    mss_softstart_sequencer dut (
        .REF_CLK(REF_CLK), .RST(RST), .PHASE_DRIVE_IN(pin), .PHASE_DRIVE_OUT(drv_out),
        .PHASE_DRIVE_OE_N(drv_oe_n), .ERROR_LEVEL(err_lvl), .TARGET_LEVEL(tgt_lvl),
        .CURRENT_PH1(cur), .CURRENT_PH2(cur_hi), .CURRENT_PH3(cur), .CURRENT_PH4(cur),
        .OVERCURRENT_IN(oc), .CORE_SENSE_IN(core), .POWER_GOOD_OUT(pg_out), .POWER_GOOD_OE_N(pg_oe_n),
        .REFERENCE_LEVEL(ref_lvl), .ACTIVE_COUNT(act_cnt));
    mss_gate_model u_drv (.tie(tie), .drive_out(drv_out), .drive_oe_n(drv_oe_n), .pin(pin));
    task automatic stop_test();
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [18:0] got, input logic [18:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask
    task automatic at(input int c);
        while (cyc < c) tick(1);
    endtask
    task automatic note(input logic [18:0] exp);
        exp_q.push_back(exp);
        ->ev;
    endtask
    // Bounded wait for a phase level; k holds the cycles spent
    task automatic w(input int i, input logic v);
        k = 19'h0;
        while (drv_out[i] !== v && k < 19'h258) begin
            tick(1);
            k++;
        end
    endtask
    always #5 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) begin
        total <= total + 1;
        cyc <= RST ? 0 : cyc + 1;
        if (total == 70000) begin
            errors++;
            stop_test();
        end
    end
    always @(ev) check({drv_oe_n, drv_out & ~drv_oe_n, act_cnt, ref_lvl}, exp_q.pop_front());
    initial begin
        void'($urandom(73));
        err_lvl = $urandom_range(255, 8);
        tgt_lvl = $urandom_range(255, 8);
        cur = $urandom_range(200, 0);
        cur_hi = cur;
        core = $urandom_range(1, 0);
        tick(16);
        RST = 1'b0;
        at(8100);
        note({4'hF, 4'h0, 3'h4, 8'h00});
        at(8400);
        note({4'h8, 4'h0, 3'h3, 8'h00});
        at(46500);
        note({4'h8, 4'h0, 3'h3, 8'h00});
        at(50000);
        note({4'h8, 4'h0, 3'h3, 8'h03});
        check({17'h0, pg_out, pg_oe_n}, 19'h0);
        w(0, 1'b1);
        w(0, 1'b0);
        check(k, 19'h3);
        w(1, 1'b1);
        check(k, 19'h52);
        w(2, 1'b1);
        check(k, 19'h56);
        // Second phase far above average with small demand: no pulse for two periods
        err_lvl = 8'h10;
        cur_hi = cur + 8'h30;
        w(1, 1'b1);
        check(k, 19'h258);
        // Zero demand at a period start, where phase 1 would otherwise pulse
        cur_hi = cur;
        err_lvl = 8'h00;
        at(51201);
        note({4'h8, 4'h0, 3'h3, 8'h04});
        oc = 1'b1;
        tick(4);
        oc = 1'b0;
        tick(4);
        note({4'hF, 4'h0, 3'h3, 8'h00});
        base = cyc;
        at(base + 8000);
        note({4'hF, 4'h0, 3'h3, 8'h00});
        at(base + 8400);
        note({4'h8, 4'h0, 3'h3, 8'h00});
        RST = 1'b1;
        tick(2);
        note({4'hF, 4'h0, 3'h4, 8'h00});
        // Let the watcher take the last note before the verdict
        tick(1);
        stop_test();
    end
endmodule // multiphase_softstart_sequencer_bench
